/* File: inc/csw_params.svh */
/*
  Constants for the selective wake flag and transceiver mode block.
  Assumes a 100 MHz core clock and a 32-bit APB register bus.
*/
`ifndef CSW_PARAMS_SVH
`define CSW_PARAMS_SVH

// ****************************************
// Timing
// ****************************************
`define CSW_CLK_MHZ 100
`define CSW_T_SILENCE_US 1000
`define CSW_SIL_CNT_W 32

// ****************************************
// Register byte offsets and bus widths
// ****************************************
`define CSW_ADDR_W 8
`define CSW_OFF_MODE_CTRL 8'h00
`define CSW_OFF_IRQ_MASK 8'h04
`define CSW_OFF_STATUS 8'h08
`define CSW_OFF_STATE 8'h0c

// ****************************************
// Status and state register fields
// ****************************************
`define CSW_ST_TIMEOUT 0
`define CSW_ST_SILENCE 1
`define CSW_ST_LOCK 2
`define CSW_ST_ARMED 3
`define CSW_ST_ERROR 4
`define CSW_ST_PWAKE 5
`define CSW_ST_FWAKE 6
`define CSW_ST_ECNT_LO 8
`define CSW_ST_ECNT_HI 13
`define CSW_SE_CHIP_LO 0
`define CSW_SE_CHIP_HI 1
`define CSW_SE_SWK_LO 4
`define CSW_SE_SWK_HI 6

// ****************************************
// Transceiver mode codes, reset values and error counter constants
// ****************************************
`define CSW_MODE_OFF 3'h0
`define CSW_MODE_WAKE 3'h1
`define CSW_LOW_OFF 2'h0
`define CSW_LOW_WAKE 2'h1
`define CSW_LOW_RXONLY 2'h2
`define CSW_LOW_NORMAL 2'h3
`define CSW_MODE_RESET 3'h0
`define CSW_ECNT_W 6
`define CSW_ECNT_MAX 6'h1f
`define CSW_ECNT_ZERO 6'h00
`define CSW_ECNT_ONE 6'h01

`endif

/* File: inc/csw_pkg.sv */
/*
  Types for the selective wake flag and transceiver mode block.
  Assumes csw_params.svh is on the include path.
*/
`include "csw_params.svh"

package csw_pkg;

  typedef enum logic [1:0] {CHIP_NORMAL, CHIP_STOP, CHIP_SLEEP} csw_chip_mode_type;

  typedef enum logic [2:0] {
    SW_IDLE, SW_WUF_DET, SW_WUP_DET1, SW_WUP_DET2, SW_WOKEN
  } csw_swk_state_type;

  // Events from the frame decoder, one-cycle pulses except config_valid.
  typedef struct packed {
    logic valid_frame;
    logic protocol_error;
    logic wake_pattern;
    logic wake_frame_match;
    logic config_valid;
  } csw_dec_evt_type;

  typedef struct packed {
    logic rx_meta;
    logic rx_sync;
    logic rx_prev;
    logic txd_meta;
    logic txd_sync;
    logic [2:0] mode;
    logic irq_mask;
    logic to_flag;
    logic sil_flag;
    logic lock_flag;
    logic armed_flag;
    logic err_flag;
    logic pwake_flag;
    logic fwake_flag;
    logic [`CSW_ECNT_W-1:0] ecnt;
    csw_swk_state_type selective_wake;
    logic [`CSW_SIL_CNT_W-1:0] sil_cnt;
    csw_chip_mode_type chip_prev;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic to_irq;
    logic wake_irq;
    logic rx_out;
    logic bus_tx_dom;
  } csw_state_type;

endpackage

/* File: src/csw_top.sv */
/*
  One channel of selective wake status flags and transceiver mode control,
  with its registers on an APB slave.
  Assumes the chip mode and decoder events come from logic on clk, while
  the bus receive level and the transmit pin come from pins.
*/
// The implementer's own choices: the APB interface to the registers and the address map.
// Functional notes
// - Bus timeout flag sets when silence time expires in frame or pattern-2 detection.
// - Bus timeout flag stays set until software clears it.
// - Timeout raises interrupt in Stop and Normal when mask bit is one.
// - Every timeout event gives a new interrupt, even with flag still set.
// - A timeout never wakes the chip from Sleep.
// - Silence flag sets on silence expiry and clears on a wake pattern in pattern detection 1 or 2.
// - Silence flag is readable by software in Stop and Normal.
// - Frame lock sets on a valid frame, clears on a protocol error.
// - Frame lock works whenever the transceiver is on, selective wake or not.
// - Low-power entry with selective wake is allowed with frame lock clear.
// - Armed flag sets on correct enable, or after error in pattern-2 detection.
// - Armed flag clears after any wake-up or when mode bit two clears.
// - Mode bits are writable only in Normal; Stop and Sleep ignore writes.
// - Mode codes: off, wake, receive only, normal, and selective wake variants.
// - Normal with selective wake passes data while the wake logic monitors.
// - Wake frame in normal with selective wake interrupts without pulling receive low.
// - Receive only with selective wake delivers data and never drives the bus.
// - Error flag zero means selective wake enabled and no counter overflow.
// - Readback shows programmed mode in Normal; leaving Normal may alter low bits.
// - Stop entry maps 011 to 001 and 111 to 101; error drops selective wake.
// - Error flag stops frame detection but keeps mode bit two stored.
// - Error flag sets on configuration error and on counter overflow.
// - Increment from 31 disables selective wake, wakes, and sets the error flag.
`timescale 1ns/1ns

module csw_top import csw_pkg::*; #(
  parameter int SILENCE_US = `CSW_T_SILENCE_US
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`CSW_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Chip mode and frame decoder
  input wire csw_chip_mode_type chip_mode,
  input wire csw_dec_evt_type dec_evt,
  // Bus and controller pins
  input wire logic bus_rx_level,
  input wire logic transmit_pin_x,
  output logic receive_pin_x,
  output logic bus_tx_dominant,
  // Interrupt pulses
  output logic bus_timeout_irq,
  output logic can_wake_irq
);

  // ****************************************
  // Constants and decode helpers
  // ****************************************
  localparam logic [`CSW_SIL_CNT_W-1:0] SILENCE_CYCLES =
    `CSW_SIL_CNT_W'(SILENCE_US * `CSW_CLK_MHZ);

  function automatic logic addr_known(input logic [`CSW_ADDR_W-1:0] a);
    addr_known = (a == `CSW_OFF_MODE_CTRL) || (a == `CSW_OFF_IRQ_MASK) ||
                 (a == `CSW_OFF_STATUS) || (a == `CSW_OFF_STATE);
  endfunction

  // A mode is selective wake when bit two is set and the transceiver is not off.
  function automatic logic is_swk_mode(input logic [2:0] m);
    is_swk_mode = m[2] && (m[1:0] != `CSW_LOW_OFF);
  endfunction

  // Effective low mode bits once Normal is left; bit two is never touched.
  function automatic logic [1:0] low_power_map(input logic [1:0] low, input logic sleep);
    low_power_map = low;
    if (low == `CSW_LOW_NORMAL) begin
      low_power_map = `CSW_LOW_WAKE;
    end else if (sleep && low == `CSW_LOW_RXONLY) begin
      low_power_map = `CSW_LOW_WAKE;
    end
  endfunction

  // ****************************************
  // Behaviour summary
  // ****************************************
  // The channel keeps its whole state in one packed register. Software sees four words:
  // the programmed transceiver mode, the timeout interrupt mask, the status flags and
  // a read-only view of the chip mode and the selective wake sequencer.
  //
  // Decoder events, single-cycle pulses apart from the config_valid level, come from logic on this clock, so they
  // pass no synchroniser. Only the bus receive level and the transmit pin come from
  // pins and are brought in through two flip-flops first.
  //
  // The silence timer only runs in frame detection and pattern detection 2. Any bus
  // edge or dominant level restarts it. In frame detection an expiry moves the
  // sequencer to pattern detection 1; in pattern detection 2 the timer simply runs
  // again, so every further silent period raises a new timeout event.
  //
  // A mode write is the only way out of the woken state. It rearms the sequencer and
  // clears both wake source flags, and the configuration check runs in the next cycle.
  // A user must therefore set the configuration valid level before writing the mode.
  //
  // Leaving Normal rewrites only the two low mode bits. Bit two is kept, so software can
  // still see that a selective wake mode was chosen even when an error disabled it.

  csw_state_type s_reg;
  csw_state_type s_next;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    logic setup;
    logic wr;
    logic active_chip;
    logic rx_activity;
    logic sil_expire;
    logic timed_state;
    logic wake_ev;
    logic ecnt_en;
    logic mode_wr;
    logic [31:0] rd;
    setup = 1'b0;
    wr = 1'b0;
    active_chip = 1'b0;
    rx_activity = 1'b0;
    sil_expire = 1'b0;
    timed_state = 1'b0;
    wake_ev = 1'b0;
    ecnt_en = 1'b0;
    mode_wr = 1'b0;
    rd = '0;
    s_next = s_reg;

    // Pin synchronisers.
    s_next.rx_meta = bus_rx_level;
    s_next.rx_sync = s_reg.rx_meta;
    s_next.rx_prev = s_reg.rx_sync;
    s_next.txd_meta = transmit_pin_x;
    s_next.txd_sync = s_reg.txd_meta;
    s_next.chip_prev = chip_mode;
    s_next.to_irq = 1'b0;
    s_next.wake_irq = 1'b0;

    setup = psel && !penable;
    wr = psel && penable && s_reg.pready && pwrite;
    active_chip = (chip_mode == CHIP_NORMAL) || (chip_mode == CHIP_STOP);
    mode_wr = wr && paddr == `CSW_OFF_MODE_CTRL && chip_mode == CHIP_NORMAL;

    // Silence timer, restarted by any edge or dominant level on the bus.
    rx_activity = (s_reg.rx_sync != s_reg.rx_prev) || !s_reg.rx_sync;
    timed_state = (s_reg.selective_wake == SW_WUF_DET) || (s_reg.selective_wake == SW_WUP_DET2);
    if (!timed_state || rx_activity) begin
      s_next.sil_cnt = '0;
    end else if (s_reg.sil_cnt == SILENCE_CYCLES - 1'b1) begin
      sil_expire = 1'b1;
      s_next.sil_cnt = '0;
    end else begin
      s_next.sil_cnt = s_reg.sil_cnt + 1'b1;
    end

    // ****************************************
    // Register writes
    // ****************************************
    if (mode_wr) begin
      s_next.mode = pwdata[2:0];
      s_next.selective_wake = SW_IDLE;
      s_next.pwake_flag = 1'b0;
      s_next.fwake_flag = 1'b0;
    end
    if (wr && paddr == `CSW_OFF_IRQ_MASK) begin
      s_next.irq_mask = pwdata[0];
    end
    if (wr && paddr == `CSW_OFF_STATUS) begin
      if (pwdata[`CSW_ST_TIMEOUT]) begin
        s_next.to_flag = 1'b0;
      end
      // An invalid configuration keeps the error flag from being cleared.
      if (pwdata[`CSW_ST_ERROR] && !(s_reg.mode[2] && !dec_evt.config_valid)) begin
        s_next.err_flag = 1'b0;
      end
    end

    // Leaving Normal rewrites the low bits to the effective mode.
    if (s_reg.chip_prev == CHIP_NORMAL && chip_mode != CHIP_NORMAL) begin
      s_next.mode[1:0] = low_power_map(s_reg.mode[1:0], chip_mode == CHIP_SLEEP);
    end

    // ****************************************
    // Selective wake sequencing
    // ****************************************
    unique case (s_reg.selective_wake)
      SW_IDLE: begin
        if (mode_wr) begin
          s_next.selective_wake = SW_IDLE;
        end else if (is_swk_mode(s_reg.mode)) begin
          s_next.armed_flag = 1'b1;
          s_next.ecnt = `CSW_ECNT_ZERO;
          if (dec_evt.config_valid) begin
            s_next.err_flag = 1'b0;
            s_next.selective_wake = SW_WUF_DET;
          end else begin
            s_next.err_flag = 1'b1;
            s_next.selective_wake = SW_WUP_DET2;
          end
        end else begin
          s_next.armed_flag = 1'b0;
          if (s_reg.mode == `CSW_MODE_WAKE && dec_evt.wake_pattern) begin
            s_next.pwake_flag = 1'b1;
            s_next.selective_wake = SW_WOKEN;
            wake_ev = 1'b1;
          end
        end
      end
      SW_WUF_DET: begin
        if (dec_evt.protocol_error && s_reg.ecnt == `CSW_ECNT_MAX) begin
          s_next.err_flag = 1'b1;
          s_next.armed_flag = 1'b0;
          s_next.selective_wake = SW_WOKEN;
          wake_ev = 1'b1;
        end else if (dec_evt.wake_frame_match && !s_reg.err_flag) begin
          s_next.fwake_flag = 1'b1;
          s_next.armed_flag = 1'b0;
          s_next.selective_wake = SW_WOKEN;
          wake_ev = 1'b1;
        end else if (sil_expire) begin
          s_next.sil_flag = 1'b1;
          s_next.ecnt = `CSW_ECNT_ZERO;
          s_next.selective_wake = SW_WUP_DET1;
        end
      end
      SW_WUP_DET1: begin
        if (dec_evt.wake_pattern) begin
          s_next.sil_flag = 1'b0;
          s_next.pwake_flag = 1'b1;
          s_next.ecnt = `CSW_ECNT_ZERO;
          s_next.selective_wake = SW_WUF_DET;
        end
      end
      SW_WUP_DET2: begin
        if (dec_evt.wake_pattern) begin
          s_next.sil_flag = 1'b0;
          s_next.pwake_flag = 1'b1;
          s_next.armed_flag = 1'b0;
          s_next.selective_wake = SW_WOKEN;
          wake_ev = 1'b1;
        end else if (sil_expire) begin
          s_next.sil_flag = 1'b1;
        end
      end
      SW_WOKEN: begin
        s_next.armed_flag = 1'b0;
      end
      default: begin
        s_next.selective_wake = SW_IDLE;
      end
    endcase
    if (!s_reg.mode[2]) begin
      s_next.armed_flag = 1'b0;
    end

    // Timeout flag and interrupt; the set beats a clear in the same cycle.
    if (sil_expire) begin
      s_next.to_flag = 1'b1;
      s_next.to_irq = s_reg.irq_mask && active_chip;
    end
    s_next.wake_irq = wake_ev && active_chip;

    // ****************************************
    // Protocol error counter and frame lock
    // ****************************************
    ecnt_en = (s_reg.mode[1] || s_reg.selective_wake == SW_WUF_DET) && s_reg.selective_wake != SW_WOKEN;
    if (s_reg.mode[1:0] == `CSW_LOW_OFF || s_reg.mode == `CSW_MODE_WAKE) begin
      s_next.ecnt = `CSW_ECNT_ZERO;
    end else if (ecnt_en && s_next.selective_wake != SW_WUP_DET1) begin
      if (dec_evt.protocol_error) begin
        s_next.ecnt = s_reg.ecnt + `CSW_ECNT_ONE;
      end else if (dec_evt.valid_frame && s_reg.ecnt != `CSW_ECNT_ZERO) begin
        s_next.ecnt = s_reg.ecnt - `CSW_ECNT_ONE;
      end
    end
    // Lock never gates low-power entry, so a silent bus cannot block it.
    if (s_reg.mode[1:0] != `CSW_LOW_OFF) begin
      if (dec_evt.protocol_error) begin
        s_next.lock_flag = 1'b0;
      end else if (dec_evt.valid_frame) begin
        s_next.lock_flag = 1'b1;
      end
    end

    // ****************************************
    // Transceiver data path
    // ****************************************
    if (s_reg.mode[1] && active_chip) begin
      s_next.rx_out = s_reg.rx_sync;
    end else begin
      s_next.rx_out = !(s_reg.selective_wake == SW_WOKEN && s_reg.pwake_flag);
    end
    s_next.bus_tx_dom = chip_mode == CHIP_NORMAL && s_reg.mode[1:0] == `CSW_LOW_NORMAL &&
                        !s_reg.txd_sync;

    // ****************************************
    // APB answer: zero wait states, data latched in the setup cycle
    // ****************************************
    unique case (paddr)
      `CSW_OFF_MODE_CTRL: rd[2:0] = s_reg.mode;
      `CSW_OFF_IRQ_MASK: rd[0] = s_reg.irq_mask;
      `CSW_OFF_STATUS: begin
        rd[`CSW_ST_TIMEOUT] = s_reg.to_flag;
        rd[`CSW_ST_SILENCE] = s_reg.sil_flag;
        rd[`CSW_ST_LOCK] = s_reg.lock_flag;
        rd[`CSW_ST_ARMED] = s_reg.armed_flag;
        rd[`CSW_ST_ERROR] = s_reg.err_flag;
        rd[`CSW_ST_PWAKE] = s_reg.pwake_flag;
        rd[`CSW_ST_FWAKE] = s_reg.fwake_flag;
        rd[`CSW_ST_ECNT_HI:`CSW_ST_ECNT_LO] = s_reg.ecnt;
      end
      `CSW_OFF_STATE: begin
        rd[`CSW_SE_CHIP_HI:`CSW_SE_CHIP_LO] = chip_mode;
        rd[`CSW_SE_SWK_HI:`CSW_SE_SWK_LO] = s_reg.selective_wake;
      end
      default: rd = '0;
    endcase
    s_next.pready = setup;
    if (setup) begin
      s_next.prdata = pwrite ? '0 : rd;
      s_next.pslverr = !addr_known(paddr);
    end else if (!psel) begin
      s_next.prdata = '0;
      s_next.pslverr = 1'b0;
    end
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.rx_meta <= 1'b1;
      s_reg.rx_sync <= 1'b1;
      s_reg.rx_prev <= 1'b1;
      s_reg.txd_meta <= 1'b1;
      s_reg.txd_sync <= 1'b1;
      s_reg.rx_out <= 1'b1;
      s_reg.mode <= `CSW_MODE_RESET;
      s_reg.selective_wake <= SW_IDLE;
      s_reg.chip_prev <= CHIP_NORMAL;
    end else begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign receive_pin_x = s_reg.rx_out;
  assign bus_tx_dominant = s_reg.bus_tx_dom;
  assign bus_timeout_irq = s_reg.to_irq;
  assign can_wake_irq = s_reg.wake_irq;

endmodule

/* File: verif/csw_bus_model.sv */
/*
  Far side of the channel: bus level and frame decoder events.
  Assumes the bench requests each event one cycle ahead.
*/
`timescale 1ns/1ns
module csw_bus_model import csw_pkg::*; (
  // Clock and requests
  input wire logic clk,
  input wire logic chatter,
  input wire logic cfg_ok,
  input wire logic [3:0] pulse_req,
  // Towards the block
  output logic bus_rx_level,
  output csw_dec_evt_type dec_evt
);
  initial bus_rx_level = 1'b1;
  initial dec_evt = '0;
  // An idle bus rests recessive; traffic flips it every cycle.
  always @(posedge clk) begin
    bus_rx_level <= chatter ? ~bus_rx_level : 1'b1;
    dec_evt <= {pulse_req, cfg_ok};
  end
endmodule

/* File: verif/csw_top_asserts.sv */
/*
  Port checker for one selective wake channel.
  Assumes the bench binds it to csw_top and hands on SILENCE_US.
*/
`timescale 1ns/1ns
`include "csw_params.svh"
module csw_top_asserts import csw_pkg::*; #(
  parameter int SILENCE_US = 1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic [`CSW_ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Channel
  input wire csw_chip_mode_type chip_mode,
  input wire logic bus_rx_level,
  input wire logic bus_tx_dominant,
  input wire logic bus_timeout_irq,
  input wire logic can_wake_irq
);
  // ****************************************
  // Helper logic
  // ****************************************
  localparam int SIL_CYC = SILENCE_US * `CSW_CLK_MHZ;
  int quiet_reg;
  int quiet_next;
  // Cycles of recessive bus; a timeout may not come sooner than a full period.
  always_comb quiet_next = bus_rx_level ? quiet_reg + 1 : 0;
  always_ff @(posedge clk) quiet_reg <= rst ? 0 : quiet_next;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence
  a_apb_answer: assert property (s_setup |=> s_access)
    else $error("no ready in the access cycle");
  a_ready_placed: assert property (pready |-> $past(psel && !penable) && penable)
    else $error("ready outside an access cycle");
  a_addr_error: assert property (s_setup |=> pslverr == !($past(paddr) inside {
    `CSW_OFF_MODE_CTRL, `CSW_OFF_IRQ_MASK, `CSW_OFF_STATUS, `CSW_OFF_STATE}))
    else $error("error response wrong for address");
  a_error_zero: assert property (pready && pslverr |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_timeout_quiet: assert property (bus_timeout_irq |-> quiet_reg >= SIL_CYC)
    else $error("timeout before a full silent period");
  a_timeout_pulse: assert property (bus_timeout_irq |=> !bus_timeout_irq [*8])
    else $error("timeout interrupt not a single pulse");
  a_sleep_timeout: assert property (bus_timeout_irq |-> $past(chip_mode) != CHIP_SLEEP)
    else $error("timeout interrupt in sleep");
  a_wake_pulse: assert property (can_wake_irq |=> !can_wake_irq)
    else $error("wake interrupt not a single pulse");
  a_tx_quiet: assert property ((chip_mode != CHIP_NORMAL) [*3] |=> !bus_tx_dominant)
    else $error("bus driven outside normal chip mode");
endmodule

/* File: verif/tb_top.sv */
/*
  Self-checking bench for one selective wake channel.
  Assumes csw_pkg, the checker and the bus model are compiled first.
*/
`timescale 1ns/1ns
`include "csw_params.svh"
module tb_top import csw_pkg::*;;
  localparam int SIL = 100;
  localparam logic [3:0] P_VF = 4'h8;
  localparam logic [3:0] P_PE = 4'h4;
  localparam logic [3:0] P_WP = 4'h2;
  localparam logic [3:0] P_WF = 4'h1;
  logic clk = 1'b0;
  logic rst, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  csw_chip_mode_type chip_mode;
  csw_dec_evt_type dec_evt;
  logic bus_rx_level, transmit_pin_x, receive_pin_x, bus_tx_dominant;
  logic bus_timeout_irq, can_wake_irq, chatter, cfg_ok;
  logic [3:0] pulse_req;
  int errors = 0;
  int checks_done = 0;
  int n_to = 0;
  int n_wk = 0;

  always #5 clk = ~clk;
  csw_top #(.SILENCE_US(1)) i_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .chip_mode, .dec_evt, .bus_rx_level, .transmit_pin_x,
    .receive_pin_x, .bus_tx_dominant, .bus_timeout_irq, .can_wake_irq);
  csw_bus_model i_bus (.clk, .chatter, .cfg_ok, .pulse_req, .bus_rx_level, .dec_evt);

  // Interrupt pulses are counted away from the edge that launches them.
  always @(negedge clk) begin
    n_to <= n_to + 32'(bus_timeout_irq === 1'b1);
    n_wk <= n_wk + 32'(can_wake_irq === 1'b1);
  end

  // ****************************************
  // Tasks and functions
  // ****************************************
  task automatic complete_run();
    if (errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check_value(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic er);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Ready, data and error are taken at the very edge that completes the access.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    check_value({31'h0, pready}, 32'h1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic er;
    apb(1'b1, a, d, rd, er);
  endtask
  task automatic rd_check(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] e);
    logic [31:0] rd;
    logic er;
    apb(1'b0, a, 32'h0, rd, er);
    check_value(rd & msk, e);
  endtask
  task automatic pulse(input logic [3:0] p);
    @(posedge clk);
    pulse_req <= p;
    @(posedge clk);
    pulse_req <= 4'h0;
    repeat (2) @(posedge clk);
  endtask
  task automatic wait_to(input int want, input int lim);
    for (int k = 0; k < lim && n_to < want; k++) @(posedge clk);
  endtask
  // Leaving Normal turns normal-with-transmit into wake capable, top bit kept.
  function automatic logic [31:0] exp_stop_mode(input logic [2:0] m);
    return (m[1:0] == 2'h3) ? {29'h0, m[2], 2'h1} : {29'h0, m};
  endfunction

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    #300000;
    errors++;
    complete_run();
  end
  initial begin
    logic [31:0] rd;
    logic er, c;
    logic [2:0] m;
    int b;
    rst = 1'b1;
    {psel, penable, pwrite, transmit_pin_x, chatter, cfg_ok} = 6'b000111;
    paddr = 8'h0;
    pwdata = 32'h0;
    pulse_req = 4'h0;
    chip_mode = CHIP_NORMAL;
    b = $urandom(32'h180bde51);
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_check(`CSW_OFF_MODE_CTRL, 32'hffffffff, 32'h0);
    rd_check(`CSW_OFF_STATUS, 32'hffffffff, 32'h0);
    apb(1'b0, 8'h10, 32'h0, rd, er);
    check_value(rd, 32'h0);
    check_value({31'h0, er}, 32'h1);
    for (int i = 0; i < 8; i++) begin
      m = 3'(i);
      c = 1'($urandom & 1);
      chip_mode <= CHIP_NORMAL;
      cfg_ok <= c;
      wr(`CSW_OFF_MODE_CTRL, ($urandom & 32'hfffffff8) | 32'(m));
      rd_check(`CSW_OFF_MODE_CTRL, 32'hffffffff, 32'(m));
      if (m[2] && m[1:0] != 2'h0)
        rd_check(`CSW_OFF_STATUS, 32'h18, c ? 32'h8 : 32'h18);
      chip_mode <= CHIP_STOP;
      repeat (3) @(posedge clk);
      wr(`CSW_OFF_MODE_CTRL, 32'(~m));
      rd_check(`CSW_OFF_MODE_CTRL, 32'hffffffff, exp_stop_mode(m));
    end
    chip_mode <= CHIP_NORMAL;
    cfg_ok <= 1'b1;
    wr(`CSW_OFF_MODE_CTRL, 32'h3);
    pulse(P_VF);
    rd_check(`CSW_OFF_STATUS, 32'h4, 32'h4);
    pulse(P_PE);
    rd_check(`CSW_OFF_STATUS, 32'h4, 32'h0);
    wr(`CSW_OFF_IRQ_MASK, 32'h1);
    wr(`CSW_OFF_MODE_CTRL, 32'h7);
    transmit_pin_x <= 1'b0;
    repeat (6) @(negedge clk);
    check_value({31'h0, bus_tx_dominant}, 32'h1);
    @(posedge clk);
    transmit_pin_x <= 1'b1;
    chatter <= 1'b0;
    b = n_to;
    wait_to(b + 1, 2 * SIL);
    check_value(32'(n_to - b), 32'h1);
    rd_check(`CSW_OFF_STATUS, 32'h3, 32'h3);
    wr(`CSW_OFF_STATUS, 32'h1);
    rd_check(`CSW_OFF_STATUS, 32'h3, 32'h2);
    chatter <= 1'b1;
    pulse(P_WP);
    chatter <= 1'b0;
    rd_check(`CSW_OFF_STATUS, 32'h2, 32'h0);
    b = n_wk;
    pulse(P_WF);
    repeat (3) @(negedge clk);
    check_value(32'(n_wk - b), 32'h1);
    check_value({31'h0, receive_pin_x}, 32'h1);
    rd_check(`CSW_OFF_STATUS, 32'h48, 32'h40);
    chatter <= 1'b1;
    wr(`CSW_OFF_MODE_CTRL, 32'h5);
    b = n_wk;
    repeat (32) pulse(P_PE);
    rd_check(`CSW_OFF_STATUS, 32'h3f10, 32'h2010);
    check_value(32'(n_wk - b), 32'h1);
    cfg_ok <= 1'b0;
    wr(`CSW_OFF_IRQ_MASK, 32'h0);
    wr(`CSW_OFF_MODE_CTRL, 32'h5);
    chatter <= 1'b0;
    b = n_to;
    repeat (SIL + 30) @(posedge clk);
    check_value(32'(n_to - b), 32'h0);
    rd_check(`CSW_OFF_STATUS, 32'h1, 32'h1);
    wr(`CSW_OFF_IRQ_MASK, 32'h1);
    b = n_to;
    wait_to(b + 2, 3 * SIL);
    check_value(32'(n_to - b), 32'h2);
    chip_mode <= CHIP_STOP;
    b = n_to;
    wait_to(b + 1, 2 * SIL);
    check_value(32'(n_to - b), 32'h1);
    chip_mode <= CHIP_SLEEP;
    b = n_to;
    repeat (2 * SIL) @(posedge clk);
    check_value(32'(n_to - b), 32'h0);
    complete_run();
  end
endmodule

bind csw_top csw_top_asserts #(.SILENCE_US(SILENCE_US)) i_chk (.clk, .rst, .psel, .penable,
  .paddr, .prdata, .pready, .pslverr, .chip_mode, .bus_rx_level, .bus_tx_dominant,
  .bus_timeout_irq, .can_wake_irq);
